// [panel_model.sv]
// front panel model: presses both start buttons together for a while
`timescale 1ns/100ps
module panel_model
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic press_i,
   output logic      btn_a_o,
   output logic      btn_b_o
);
   logic [3:0] hold;

   // both buttons rise and fall in the same cycle, held long enough to pass the synchroniser
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hold <= 4'h0;
      end
      else if (press_i && hold == 4'h0)
      begin
         hold <= 4'hC;
      end
      else if (hold != 4'h0)
      begin
         hold <= hold - 4'h1;
      end
   end

   assign btn_a_o = (hold != 4'h0);
   assign btn_b_o = (hold != 4'h0);
endmodule : panel_model

// [setpoint_program_sequencer_tb.sv]
// self-checking testbench of the set point program sequencer
`timescale 1ns/100ps
module setpoint_program_sequencer_tb
   import spseq_pkg::*;
;
   localparam int TK = 4;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        srst  = 1'b0;
   logic [7:0]  addr  = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        we    = 1'b0;
   logic        re    = 1'b0;
   logic [15:0] pv    = 16'h0000;
   logic [1:0]  asg   = 2'b10;
   logic        press = 1'b0;
   logic        btn_a;
   logic        btn_b;
   logic [15:0] rdata;
   logic [15:0] sp;
   logic [1:0]  pid;
   logic        aux1;
   logic        aux2;
   logic        dot;
   logic        cstop;
   logic [15:0] fixed;
   int          fails   = 0;
   int          checked = 0;
   int          cycles  = 0;

   always #5 clk = ~clk;

   spseq_top #(.TICK_CYCLES(TK)) dut
   (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
      .WE_I(we), .RE_I(re), .RDATA_O(rdata), .BTN_A_I(btn_a), .BTN_B_I(btn_b), .PV_I(pv),
      .AUX_ASSIGN_I(asg), .SP_O(sp), .PID_SEL_O(pid), .AUX_EVENT_OUTPUT_ONE_O(aux1),
      .AUX_EVENT_OUTPUT_TWO_O(aux2), .RUN_DOT_O(dot), .CTRL_STOP_O(cstop), .FIXED_OUT_O(fixed)
   );

   panel_model panel
   (
      .clk_i(clk), .rst_n_i(rst_n), .press_i(press), .btn_a_o(btn_a), .btn_b_o(btn_b)
   );

   task automatic stop_test;
      if (fails == 0 && checked > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
      checked++;
      if ((got & m) !== (exp & m))
      begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      we    <= 1'b1;
      @(posedge clk);
      we    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk);
      addr <= a;
      re   <= 1'b1;
      @(posedge clk);
      re   <= 1'b0;
      #1;
      chk(rdata, e, m);
   endtask : rd

   task automatic seg(input logic [3:0] p, input logic [3:0] s, input logic [15:0] ctl,
                      input logic [15:0] tgt, input logic [15:0] par, input logic [15:0] lck);
      wr(A_SEL, {8'h00, p, s});
      wr(A_SCTL, ctl);
      wr(A_STGT, tgt);
      wr(A_SPAR, par);
      wr(A_SLCK, lck);
   endtask : seg

   task automatic wait_dot(input logic v);
      int n;
      n = 0;
      #1;
      while (dot !== v && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({15'h0000, dot}, {15'h0000, v}, 16'h0001);
   endtask : wait_dot

   task automatic start;
      @(posedge clk);
      press <= 1'b1;
      @(posedge clk);
      press <= 1'b0;
   endtask : start

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         $display("BAD %0t run did not finish", $time);
         stop_test();
      end
   end

   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(A_CFG, CFG_RST, 16'hFFFF);
      wr(A_AFTER, 16'h1234);
      wr(A_FIXED, 16'h5A5A);
      rd(A_AFTER, 16'h0000, 16'hFFFF);
      chk(fixed, 16'h0000, 16'hFFFF);
      rd(8'h20, 16'h0000, 16'hFFFF);
      wr(A_CFG, 16'h0421);
      rd(A_CFG, 16'h0421, 16'hFFFF);
      rd(A_AFTER, WORD_RST, 16'hFFFF);
      wr(A_PTIME, 16'd20);
      // program 1, run twice: time ramp to 100, dwell, end with aux two only
      seg(4'h1, 4'h0, 16'h002C, 16'd100, 16'd4, 16'h0000);
      seg(4'h1, 4'h1, 16'h0002, 16'h0000, 16'd2, 16'h0000);
      seg(4'h1, 4'h2, 16'h000B, 16'h0000, 16'h0000, 16'h0000);
      seg(4'hE, 4'hE, 16'h0033, 16'h0000, 16'h0000, 16'h0000);
      rd(A_SCTL, 16'h0033, 16'h003F);
      wr(A_SEL, 16'h00FF);
      wr(A_SCTL, 16'h0001);
      rd(A_SCTL, 16'h0000, 16'hFFFF);
      start();
      wait_dot(1'b1);
      rd(A_STAT, 16'h0009, 16'h07FF);
      chk({14'h0000, pid}, 16'h0002, 16'h0003);
      chk({14'h0000, aux2, aux1}, 16'h0002, 16'h0003);
      rd(A_CYC, 16'h0002, 16'hFFFF);
      wait_dot(1'b0);
      rd(A_STAT, 16'h000B, 16'h007F);
      rd(A_CYC, 16'h0000, 16'hFFFF);
      rd(A_PREM, 16'd8, 16'hFFFF);
      rd(A_SP, 16'd100, 16'hFFFF);
      chk(sp, 16'd100, 16'hFFFF);
      chk({14'h0000, aux2, aux1}, 16'h0002, 16'h0003);
      chk({15'h0000, cstop}, 16'h0001, 16'h0001);
      // program 2: lower lock, rate ramp from zero
      wr(A_CFG, 16'h0243);
      asg <= 2'b11;
      seg(4'h2, 4'h0, 16'h000D, 16'd1000, 16'd10, 16'd5);
      seg(4'h2, 4'h1, 16'h0003, 16'h0000, 16'h0000, 16'h0000);
      start();
      wait_dot(1'b1);
      repeat (6 * TK) @(posedge clk);
      rd(A_STAT, 16'h0005, 16'h0007);
      chk(sp, 16'd10, 16'hFFFF);
      chk({14'h0000, aux2, aux1}, 16'h0003, 16'h0003);
      wait_dot(~dot);
      wr(A_CFG, 16'h0245);
      repeat (3 * TK) @(posedge clk);
      rd(A_STAT, 16'h0001, 16'h0007);
      @(posedge clk);
      pv <= 16'h7FFF;
      repeat (3 * TK) @(posedge clk);
      rd(A_STAT, 16'h0005, 16'h0007);
      wr(A_CFG, 16'h0247);
      pv <= 16'h0000;
      repeat (3 * TK) @(posedge clk);
      rd(A_STAT, 16'h0005, 16'h0007);
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      rd(A_STAT, 16'h0000, 16'h0007);
      chk({13'h0000, dot, aux2, aux1}, 16'h0000, 16'h0007);
      wr(A_CFG, 16'h0242);
      start();
      repeat (30) @(posedge clk);
      #1;
      chk({15'h0000, dot}, 16'h0000, 16'h0001);
      // program 2 again, lock off, ending on the after-program set point
      wr(A_CFG, 16'h0251);
      wr(A_FIXED, 16'h0F0F);
      wr(A_AFTER, 16'd77);
      pv <= 16'd900;
      rd(A_AFTER, 16'd77, 16'hFFFF);
      chk(fixed, 16'h0F0F, 16'hFFFF);
      start();
      wait_dot(1'b1);
      wait_dot(1'b0);
      chk(sp, 16'd77, 16'hFFFF);
      chk({14'h0000, aux2, aux1}, 16'h0000, 16'h0003);
      chk({15'h0000, cstop}, 16'h0000, 16'h0001);
      stop_test();
   end
endmodule : setpoint_program_sequencer_tb

// [spseq_pkg.sv]
// constants and types of the set point program sequencer
package spseq_pkg;
   localparam int          NPROG     = 15;
   localparam int          NSEG      = 15;
   localparam int          NSLOT     = NPROG * NSEG;
   localparam int          CLK_MHZ   = 100;
   localparam int          TICK_MS   = 100;
   localparam int          TICK_CYC  = TICK_MS * 1000 * CLK_MHZ;
   localparam int          BLINK_TK  = 5;
   localparam logic [7:0]  A_CFG     = 8'h00;
   localparam logic [7:0]  A_AFTER   = 8'h01;
   localparam logic [7:0]  A_FIXED   = 8'h02;
   localparam logic [7:0]  A_SEL     = 8'h03;
   localparam logic [7:0]  A_SCTL    = 8'h04;
   localparam logic [7:0]  A_STGT    = 8'h05;
   localparam logic [7:0]  A_SPAR    = 8'h06;
   localparam logic [7:0]  A_SLCK    = 8'h07;
   localparam logic [7:0]  A_PTIME   = 8'h08;
   localparam logic [7:0]  A_STAT    = 8'h10;
   localparam logic [7:0]  A_CYC     = 8'h11;
   localparam logic [7:0]  A_SEL_T   = 8'h12;
   localparam logic [7:0]  A_SREM    = 8'h13;
   localparam logic [7:0]  A_PREM    = 8'h14;
   localparam logic [7:0]  A_SP      = 8'h15;
   localparam int          CFG_SRC   = 0;
   localparam int          CFG_LK    = 1;
   localparam int          CFG_END   = 3;
   localparam int          CFG_PRG   = 5;
   localparam int          CFG_REP   = 9;
   localparam logic [15:0] CFG_RST   = 16'h0200;
   localparam logic [15:0] WORD_RST  = 16'h0000;
   localparam logic        PROGRAM_CONTROL_SETTING = 1'b1;
   typedef enum logic [1:0] {KIND_TIME, KIND_RATE, DWELL_SEGMENT_KIND, KIND_END} kind_t;
   typedef enum logic [1:0] {LOCK_OFF, LOCK_LOWER, LOCK_UPPER, TWO_SIDED_LOCK_SETTING} lock_t;
   typedef enum logic [1:0] {END_STOP, END_HOLD_LAST, END_HOLD_AFTER} endact_t;
   typedef enum logic [1:0] {ST_STOP = 2'b00, ST_RUN = 2'b01, ST_END = 2'b11} run_t;
   typedef struct packed {
      kind_t             kind;
      logic [1:0]        aux;
      logic [1:0]        pid;
      logic signed [15:0] target;
      logic [15:0]       param;
      logic [15:0]       lock;
   } seg_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        we;
      logic        re;
   } bus_t;
endpackage : spseq_pkg

// [spseq_top.sv]
// set point program sequencer with register port, buttons and run dot
//
// How it works
// - fifteen programs are stored, chosen by program number
// - each program has up to fifteen segments run in ascending order
// - program registers are visible only while source select is program control
// - segment kinds: time, rate, dwell, end, each using its own parameters
// - each segment stores aux output states, gated by output assignment
// - in program control the set point follows the running program
// - program selection is latched when the run starts
// - both buttons together start a run only from stopped or ended
// - the display dot is lit during a run except while locked, when it blinks
// - status, program, segment, cycles and times are readable during a run
// - after the last segment, repeat while repetitions exceed one, else finish
// - after finishing on an end segment, aux outputs take its states, else they clear
// - deviation is checked only with a lock mode and nonzero threshold
// - lower lock: measured value below set point minus threshold
// - upper lock: measured value above set point plus threshold
// - two-sided lock: either condition
// - lock freezes set point and timing and blinks the dot
// - during a lock the last computed set point is still supplied
// - end action: stop with fixed output, hold last, or hold after value
// - each segment picks one of four PID sets
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module spseq_top
   import spseq_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        SRST_I,
   input  wire logic [7:0]  ADDR_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic        WE_I,
   input  wire logic        RE_I,
   output logic      [15:0] RDATA_O,
   input  wire logic        BTN_A_I,
   input  wire logic        BTN_B_I,
   input  wire logic [15:0] PV_I,
   input  wire logic [1:0]  AUX_ASSIGN_I,
   output logic      [15:0] SP_O,
   output logic      [1:0]  PID_SEL_O,
   output logic             AUX_EVENT_OUTPUT_ONE_O,
   output logic             AUX_EVENT_OUTPUT_TWO_O,
   output logic             RUN_DOT_O,
   output logic             CTRL_STOP_O,
   output logic      [15:0] FIXED_OUT_O
);
   typedef struct packed {
      run_t               st;
      logic [2:0]         sa;
      logic [2:0]         sb;
      logic               btn;
      logic [31:0]        cnt;
      logic               tick;
      logic [3:0]         bcnt;
      logic               blink;
      logic [3:0]         prog;
      logic [3:0]         seg;
      logic [15:0]        el;
      logic [15:0]        pel;
      logic [6:0]         reps;
      logic signed [15:0] sp;
      logic               lock;
      logic               dot;
      logic [1:0]         aux;
      logic [1:0]         pid;
      logic               stop;
      logic [15:0]        rdata;
      logic [15:0]        cfg;
      logic [15:0]        after_sp;
      logic [15:0]        fixed;
      logic [7:0]         sel;
      logic [15:0]        ptime;
   } state_t;

   state_t             s;
   state_t             next_s;
   seg_t               mem [0:NSLOT-1];
   seg_t               cur;
   bus_t               bus;
   logic [7:0]         cur_idx;
   logic [7:0]         sel_idx;
   logic               sel_ok;
   logic               prog_mode;
   logic               lock_en;
   logic signed [16:0] pv_x;
   logic signed [16:0] lo_lim;
   logic signed [16:0] hi_lim;
   logic               lo_hit;
   logic               hi_hit;
   logic               lock_now;

   assign bus       = '{addr: ADDR_I, wdata: WDATA_I, we: WE_I, re: RE_I};
   assign prog_mode = s.cfg[CFG_SRC] == PROGRAM_CONTROL_SETTING;
   assign cur_idx   = 8'(s.prog * NSEG + s.seg);
   assign sel_idx   = 8'(s.sel[7:4] * NSEG + s.sel[3:0]);
   assign sel_ok    = s.sel[7:4] < 4'(NPROG) && s.sel[3:0] < 4'(NSEG);
   assign cur       = mem[cur_idx];

   // deviation lock against the set point in force
   assign pv_x     = 17'(signed'(PV_I));
   assign lo_lim   = 17'(s.sp) - 17'(signed'({1'b0, cur.lock[14:0]}));
   assign hi_lim   = 17'(s.sp) + 17'(signed'({1'b0, cur.lock[14:0]}));
   assign lo_hit   = pv_x < lo_lim;
   assign hi_hit   = pv_x > hi_lim;
   assign lock_en  = lock_t'(s.cfg[CFG_LK +: 2]) != LOCK_OFF && cur.lock != 16'h0000
                     && (cur.kind == KIND_TIME || cur.kind == KIND_RATE);
   always_comb
   begin
      lock_now = 1'b0;
      if (lock_en)
      begin
         case (lock_t'(s.cfg[CFG_LK +: 2]))
            LOCK_LOWER:             lock_now = lo_hit;
            LOCK_UPPER:             lock_now = hi_hit;
            TWO_SIDED_LOCK_SETTING: lock_now = lo_hit || hi_hit;
            default:                lock_now = 1'b0;
         endcase
      end
   end

   // segment store, one field per register write
   always_ff @(posedge REF_CLK_I)
   begin
      if (bus.we && prog_mode && sel_ok)
      begin
         case (bus.addr)
            A_SCTL: {mem[sel_idx].pid, mem[sel_idx].aux, mem[sel_idx].kind}
                       <= {bus.wdata[5:4], bus.wdata[3:2], kind_t'(bus.wdata[1:0])};
            A_STGT: mem[sel_idx].target <= signed'(bus.wdata);
            A_SPAR: mem[sel_idx].param  <= bus.wdata;
            A_SLCK: mem[sel_idx].lock   <= bus.wdata;
            default: ;
         endcase
      end
   end

   always_comb
   begin
      logic               pressed;
      logic               seg_done;
      logic               pass_done;
      logic signed [16:0] diff;
      logic signed [16:0] step;
      logic [15:0]        left;
      logic [15:0]        rd;
      logic [15:0]        srem;
      next_s    = s;
      pressed   = 1'b0;
      seg_done  = 1'b0;
      pass_done = 1'b0;
      diff      = 17'(cur.target) - 17'(s.sp);
      step      = '0;
      left      = cur.param - s.el;
      rd        = WORD_RST;
      srem      = (cur.kind == KIND_RATE) ? WORD_RST : left;

      // button synchronisers, level taken when stages two and three agree
      next_s.sa = {s.sa[1:0], BTN_A_I};
      next_s.sb = {s.sb[1:0], BTN_B_I};
      if (s.sa[1] == s.sa[2] && s.sb[1] == s.sb[2])
      begin
         next_s.btn = s.sa[2] && s.sb[2];
         pressed    = next_s.btn && !s.btn;
      end

      // time base and blink rate
      next_s.tick = 1'b0;
      next_s.cnt  = s.cnt + 32'h0000_0001;
      if (s.cnt >= 32'(TICK_CYCLES - 1))
      begin
         next_s.cnt  = 32'h0000_0000;
         next_s.tick = 1'b1;
         next_s.bcnt = s.bcnt + 4'h1;
         if (s.bcnt >= 4'(BLINK_TK - 1))
         begin
            next_s.bcnt  = 4'h0;
            next_s.blink = !s.blink;
         end
      end

      // register port
      if (bus.we)
      begin
         if (bus.addr == A_CFG)
            next_s.cfg = bus.wdata;
         else if (prog_mode)
         begin
            case (bus.addr)
               A_AFTER: next_s.after_sp = bus.wdata;
               A_FIXED: next_s.fixed    = bus.wdata;
               A_SEL:   next_s.sel      = bus.wdata[7:0];
               A_PTIME: next_s.ptime    = bus.wdata;
               default: ;
            endcase
         end
      end
      if (bus.re)
      begin
         case (bus.addr)
            A_CFG:   rd = s.cfg;
            A_AFTER: rd = prog_mode ? s.after_sp : WORD_RST;
            A_FIXED: rd = prog_mode ? s.fixed : WORD_RST;
            A_SEL:   rd = prog_mode ? {8'h00, s.sel} : WORD_RST;
            A_PTIME: rd = prog_mode ? s.ptime : WORD_RST;
            A_SCTL:  rd = (prog_mode && sel_ok) ? {10'h000, mem[sel_idx].pid, mem[sel_idx].aux,
                          mem[sel_idx].kind} : WORD_RST;
            A_STGT:  rd = (prog_mode && sel_ok) ? mem[sel_idx].target : WORD_RST;
            A_SPAR:  rd = (prog_mode && sel_ok) ? mem[sel_idx].param : WORD_RST;
            A_SLCK:  rd = (prog_mode && sel_ok) ? mem[sel_idx].lock : WORD_RST;
            A_STAT:  rd = {5'h00, s.seg, s.prog, s.lock, s.st};
            A_CYC:   rd = {9'h000, s.reps};
            A_SEL_T: rd = s.el;
            A_SREM:  rd = (s.st == ST_RUN) ? srem : WORD_RST;
            A_PREM:  rd = (s.ptime > s.pel) ? s.ptime - s.pel : WORD_RST;
            A_SP:    rd = s.sp;
            default: rd = WORD_RST;
         endcase
      end
      next_s.rdata = rd;

      case (s.st)
         ST_STOP, ST_END:
         begin
            if (pressed && prog_mode && s.cfg[CFG_PRG +: 4] < 4'(NPROG))
            begin
               next_s.st   = ST_RUN;
               next_s.prog = s.cfg[CFG_PRG +: 4];
               next_s.reps = s.cfg[CFG_REP +: 7];
               next_s.seg  = 4'h0;
               next_s.el   = WORD_RST;
               next_s.pel  = WORD_RST;
               next_s.sp   = signed'(PV_I);
               next_s.stop = 1'b0;
            end
         end
         ST_RUN:
         begin
            next_s.lock = lock_now;
            next_s.pid  = cur.pid;
            next_s.aux  = cur.aux & AUX_ASSIGN_I;
            if (cur.kind == KIND_END)
               pass_done = 1'b1;
            else if (s.tick && !lock_now)
            begin
               next_s.el  = s.el + 16'h0001;
               next_s.pel = s.pel + 16'h0001;
               case (cur.kind)
                  KIND_TIME:
                  begin
                     if (s.el + 16'h0001 >= cur.param)
                     begin
                        next_s.sp = cur.target;
                        seg_done  = 1'b1;
                     end
                     else
                     begin
                        step      = diff / 17'(signed'({1'b0, left}));
                        next_s.sp = 16'(17'(s.sp) + step);
                     end
                  end
                  KIND_RATE:
                  begin
                     step = 17'(signed'({1'b0, cur.param}));
                     if (diff <= step && diff >= -step)
                     begin
                        next_s.sp = cur.target;
                        seg_done  = 1'b1;
                     end
                     else if (diff > 17'sh0_0000)
                        next_s.sp = 16'(17'(s.sp) + step);
                     else
                        next_s.sp = 16'(17'(s.sp) - step);
                  end
                  default:
                  begin
                     if (s.el + 16'h0001 >= cur.param)
                        seg_done = 1'b1;
                  end
               endcase
            end
            if (seg_done)
            begin
               next_s.el  = WORD_RST;
               next_s.seg = s.seg + 4'h1;
               pass_done  = s.seg == 4'(NSEG - 1);
            end
            if (pass_done)
            begin
               next_s.el = WORD_RST;
               if (s.reps > 7'h01)
               begin
                  next_s.reps = s.reps - 7'h01;
                  next_s.seg  = 4'h0;
               end
               else
               begin
                  next_s.st   = ST_END;
                  next_s.reps = 7'h00;
                  next_s.lock = 1'b0;
                  next_s.aux  = (cur.kind == KIND_END) ? cur.aux & AUX_ASSIGN_I : 2'b00;
                  case (endact_t'(s.cfg[CFG_END +: 2]))
                     END_STOP:       next_s.stop = 1'b1;
                     END_HOLD_AFTER: next_s.sp   = signed'(s.after_sp);
                     default:        next_s.stop = 1'b0;
                  endcase
               end
            end
         end
         default: next_s.st = ST_STOP;
      endcase

      // running dot, blinking while locked
      next_s.dot = next_s.st == ST_RUN && (!next_s.lock || s.blink);

      if (SRST_I)
      begin
         next_s.st   = ST_STOP;
         next_s.dot  = 1'b0;
         next_s.aux  = 2'b00;
         next_s.lock = 1'b0;
         next_s.stop = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         s          <= '0;
         s.cfg      <= CFG_RST;
         s.after_sp <= WORD_RST;
         s.fixed    <= WORD_RST;
         s.ptime    <= WORD_RST;
      end
      else
         s <= next_s;
   end

   assign RDATA_O                = s.rdata;
   assign SP_O                   = s.sp;
   assign PID_SEL_O              = s.pid;
   assign AUX_EVENT_OUTPUT_ONE_O = s.aux[0];
   assign AUX_EVENT_OUTPUT_TWO_O = s.aux[1];
   assign RUN_DOT_O              = s.dot;
   assign CTRL_STOP_O            = s.stop;
   assign FIXED_OUT_O            = s.fixed;

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   dot_off_idle_a: assert property (s.st != ST_RUN |-> !RUN_DOT_O)
      else $error("dot lit outside a run");
   dot_steady_a: assert property (s.st == ST_RUN && !s.lock && !SRST_I
                                  |=> RUN_DOT_O || s.st != ST_RUN || s.lock)
      else $error("dot not steady in a run");
   start_from_a: assert property ($rose(s.st == ST_RUN) |-> $past(s.st) != ST_RUN && $past(prog_mode))
      else $error("run started from wrong state");
   lock_freeze_a: assert property (s.st == ST_RUN && lock_now && !SRST_I |=> $stable(s.el) && $stable(s.sp))
      else $error("progress during lock");
   lock_gate_a: assert property (!lock_en |-> !lock_now)
      else $error("lock without mode or threshold");
   srst_clear_a: assert property (SRST_I |=> s.st == ST_STOP && !RUN_DOT_O
                                  && !AUX_EVENT_OUTPUT_ONE_O && !AUX_EVENT_OUTPUT_TWO_O)
      else $error("sync reset did not stop");
   prog_latch_a: assert property (s.st == ST_RUN |=> s.prog == $past(s.prog) || s.st != ST_RUN)
      else $error("program changed in a run");
   cfg_hide_a: assert property (!prog_mode && bus.we && bus.addr == A_FIXED |=> $stable(s.fixed))
      else $error("hidden register written");
   repeat_a: assert property (s.st == ST_RUN && cur.kind == KIND_END && s.reps > 7'h01 && !SRST_I
                              |=> s.st == ST_RUN && s.seg == 4'h0)
      else $error("repetition not restarted");
   read_hide_a: assert property (bus.re && bus.addr == A_AFTER && !prog_mode |=> RDATA_O == 16'h0000)
      else $error("hidden register read");

   run_start_c: cover property ($rose(s.st == ST_RUN));
   run_end_c: cover property ($rose(s.st == ST_END));
   lock_seen_c: cover property (s.st == ST_RUN && s.lock ##1 !s.lock);
   rate_done_c: cover property (s.st == ST_RUN && cur.kind == KIND_RATE ##1 cur.kind != KIND_RATE);
endmodule : spseq_top
